// ==== src/afp_pkg.sv ====
// Purpose: shared constants and carrier types for the amplifier fault supervisor
// Assumes: 250 MHz core clock, temperature arrives as an unsigned code in degrees C
// Notes: open-drain outputs are carried as a level plus an active-low enable
package afp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CLK_PERIOD_NS = 4;
    // short test budget per microfarad of output filter capacitance, in ms
    localparam int unsigned PIN_SHORT_CHECK_MS_PER_UF = 15;
    // the test has two steps; each step may use half of the per-uF budget
    localparam int unsigned PIN_SHORT_CHECK_STEPS = 2;
    localparam int unsigned PIN_SHORT_CHECK_UNIT_CYC_DEF = (PIN_SHORT_CHECK_MS_PER_UF * 1000 * CLK_MHZ) / PIN_SHORT_CHECK_STEPS;
    // clocks after reset until the pin synchroniser shows real levels
    localparam logic [2:0] SYNC_SETTLE_CYC = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // temperature thresholds, degrees C
    localparam logic [7:0] TEMP_WARN_LOW_C = 8'h64;  // 100
    localparam logic [7:0] TEMP_WARN_HIGH_C = 8'h7D; // 125
    localparam logic [7:0] TEMP_SHUT_C = 8'h9B;      // 155

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [3:0] HB_ALL = 4'hF;
    localparam logic [3:0] HB_NONE = 4'h0;
    localparam logic [3:0] CAP_MIN_UF = 4'h1;

    ////////////////////////////////////////////////////////////////////////////
    // startup phases
    typedef enum logic [1:0] {
        PH_POR = 2'b00,
        PH_TEST_GND = 2'b01,
        PH_TEST_PVDD = 2'b10,
        PH_RUN = 2'b11
    } afp_phase_t;

    // pin inputs, all asynchronous to clk; index 0..3 are half-bridges A..D
    typedef struct packed {
        logic [7:0] temp_c;            // junction temperature code
        logic reset_pin_n;             // reset input from the controller
        logic uv_common;               // common supply below threshold
        logic [3:0] uv_gate;           // gate_drive_supply below threshold
        logic [3:0] overload;          // overload comparator per half-bridge
        logic [3:0] boot_uv;           // bootstrap undervoltage per half-bridge
        logic [3:0] short_gnd;         // output shorted to power ground
        logic [3:0] short_pvdd;        // output shorted to power_stage_supply
        logic parallel_bridge_config;  // strap
        logic single_ended_config;     // strap
        logic three_level;             // strap: three-level temperature variant
        logic [3:0] filt_cap_uf;       // output filter capacitance, whole uF
    } afp_pins_t;

    // open-drain flags: level is always low, enable low means pulling low
    typedef struct packed {
        logic shutdown_flag_n_out;
        logic shutdown_flag_n_oe_n;
        logic overtemp_warn_n_out;
        logic overtemp_warn_n_oe_n;
        logic overtemp_warn_low_n_out;
        logic overtemp_warn_low_n_oe_n;
        logic overtemp_warn_high_n_out;
        logic overtemp_warn_high_n_oe_n;
    } afp_od_t;

    // half-bridge control
    typedef struct packed {
        logic [3:0] hiz;      // 1: both transistors off
        logic [3:0] weak_pd;  // 1: weak pulldown for bootstrap charging
    } afp_hb_t;

endpackage

// ==== src/afp_sync.sv ====
// Purpose: three-stage synchroniser for a bundle of slow pin levels
// Assumes: inputs are levels that stay put far longer than three clocks
// Notes: the bundle only moves when stages two and three agree as a whole word
`timescale 1ns/1ps
`default_nettype none
module afp_sync #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] async_in,
    output var logic [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } afp_sync_t;

    afp_sync_t s_q;
    afp_sync_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // stage one is read only by stage two; a word that is still settling
    // never reaches the output, so a multi-bit code cannot tear
    always_comb begin
        s_d = s_q;
        s_d.s1 = async_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        if (s_q.s2 == s_q.s3) begin
            s_d.val = s_q.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_out = s_q.val;

endmodule
`default_nettype wire

// ==== src/afp_ctrl.sv ====
// Purpose: fault supervision, error flags and startup short test of a 4 half-bridge stage
// Assumes: resetn is the power-on reset; all fault indications come from comparators
// Notes: every flag and half-bridge control leaves a flip-flop
// What this block does
// - Shutdown and warning outputs are open-drain, active low, pulled only on a condition.
// - Any fault that shuts the power stage pulls the shutdown flag low.
// - High warnings go low above 125C, low warning above 100C.
// - Reset input low releases the shutdown flag whatever faults exist.
// - A shutdown fault puts the stage in high impedance and pulls the flag.
// - Faults other than overload and overtemperature error recover by themselves.
// - Bootstrap undervoltage disables only its half-bridge, no latch, no flag.
// - Short test runs only at startup with common supply present.
// - A found short holds all half-bridges off until removed, then startup continues.
// - Short test checks ground shorts first, then supply shorts.
// - Test duration scales with filter capacitance, 15ms per uF.
// - During the test the flag is low and reset changes are ignored.
// - Reset after startup never restarts the short test.
// - Short test runs in bridge and parallel configs, skipped single-ended.
// - Three-level variant: warnings at 100C, 125C; above 155C latched shutdown.
// - Latched overtemperature error clears only by reset from the controller.
// - Two-level variant: one warning above 125C; above 155C latched shutdown.
// - Any supply undervoltage shuts all half-bridges and pulls the flag; auto recovers.
// - Power-on reset clears the overload state.
// - Reset input low forces every power transistor off.
// - Reset low enables weak pulldowns in bridge configs, none single-ended.
// - Latched overload clears only on a reset rising edge.
`timescale 1ns/1ps
`default_nettype none
module afp_ctrl #(
    parameter int unsigned PIN_SHORT_CHECK_UNIT_CYC = afp_pkg::PIN_SHORT_CHECK_UNIT_CYC_DEF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire afp_pkg::afp_pins_t pins,
    output var afp_pkg::afp_od_t od,
    output var afp_pkg::afp_hb_t hb
);
    import afp_pkg::*;

    localparam logic [31:0] UNIT_LAST = 32'(PIN_SHORT_CHECK_UNIT_CYC - 1);

    typedef struct packed {
        afp_phase_t phase;
        logic cfg_parallel_bridge_config;
        logic cfg_se;
        logic three_level;
        logic [3:0] cap_uf;
        logic overtemp_error;
        logic [3:0] overload_protect;
        logic rst_pin_prev;
        logic [2:0] settle;
        logic short_seen;
        logic [31:0] unit_cnt;
        logic [3:0] step_cnt;
        afp_od_t od;
        afp_hb_t hb;
    } afp_ctrl_t;

    afp_ctrl_t s_q;
    afp_ctrl_t s_d;
    afp_pins_t p;
    logic [3:0] olp_next;
    logic [3:0] pair_off;
    logic rst_low;
    logic rst_rise;
    logic uv_any;
    logic testing;
    logic test_next;
    logic short_now;
    logic glob_fault;
    logic sd_pull;
    logic [3:0] cap_eff;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    afp_sync #(
        .W($bits(afp_pins_t))
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .async_in(pins),
        .sync_out(p)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reset pin events; edges during the short test are not acted upon
    assign rst_low = ~p.reset_pin_n;
    assign testing = (s_q.phase == PH_TEST_GND) || (s_q.phase == PH_TEST_PVDD);
    assign rst_rise = p.reset_pin_n & ~s_q.rst_pin_prev & ~testing;

    // overload latches only while switching; a new overload beats the clearing edge
    assign olp_next = (s_q.overload_protect & ~{4{rst_rise}}) |
                      ((s_q.phase == PH_RUN) ? p.overload : HB_NONE);

    // a local fault takes out its pair, or the whole stage when paralleled
    for (genvar i = 0; i < 4; i++) begin : g_hb
        assign pair_off[i] = s_q.cfg_parallel_bridge_config ? (|olp_next) : (olp_next[i] | olp_next[i ^ 1]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state: phase sequence, latches and output images
    always_comb begin
        s_d = s_q;
        uv_any = p.uv_common | (|p.uv_gate);
        short_now = 1'b0;
        cap_eff = (s_q.cap_uf == 4'h0) ? CAP_MIN_UF : s_q.cap_uf;
        s_d.rst_pin_prev = p.reset_pin_n;
        s_d.overload_protect = olp_next;
        // reset low clears the error latch, except while the test owns the stage
        s_d.overtemp_error = (s_q.overtemp_error & ~(rst_low & ~testing)) | (p.temp_c > TEMP_SHUT_C);
        case (s_q.phase)
            PH_POR: begin
                // the synchroniser shows zeros for a few clocks after reset, which would
                // read as good supplies and empty straps; leave only once real levels show
                if (s_q.settle != SYNC_SETTLE_CYC) begin
                    s_d.settle = 3'(s_q.settle + 3'h1);
                end
                // straps are caught by the clock, never by the reset itself
                s_d.cfg_parallel_bridge_config = p.parallel_bridge_config;
                s_d.cfg_se = p.single_ended_config;
                s_d.three_level = p.three_level;
                s_d.cap_uf = p.filt_cap_uf;
                s_d.unit_cnt = 32'h0;
                s_d.step_cnt = 4'h0;
                if (!uv_any && (s_q.settle == SYNC_SETTLE_CYC)) begin
                    s_d.phase = p.single_ended_config ? PH_RUN : PH_TEST_GND;
                end
            end
            PH_TEST_GND, PH_TEST_PVDD: begin
                // ground shorts are checked first, supply shorts second
                short_now = (s_q.phase == PH_TEST_GND) ? (|p.short_gnd) : (|p.short_pvdd);
                s_d.short_seen = s_q.short_seen | short_now;
                if (p.uv_common) begin
                    s_d.phase = PH_POR;
                end else if (short_now) begin
                    // hold the step open until the short is gone
                    s_d.unit_cnt = 32'h0;
                    s_d.step_cnt = 4'h0;
                end else if (s_q.unit_cnt == UNIT_LAST) begin
                    s_d.unit_cnt = 32'h0;
                    if (s_q.step_cnt == 4'(cap_eff - 4'h1)) begin
                        s_d.step_cnt = 4'h0;
                        s_d.phase = (s_q.phase == PH_TEST_GND) ? PH_TEST_PVDD : PH_RUN;
                    end else begin
                        s_d.step_cnt = 4'(s_q.step_cnt + 4'h1);
                    end
                end else begin
                    s_d.unit_cnt = 32'(s_q.unit_cnt + 32'h1);
                end
            end
            PH_RUN: begin
                // once switching, nothing sends the block back into the test
                s_d.phase = PH_RUN;
            end
            default: begin
                s_d.phase = PH_POR;
            end
        endcase

        test_next = (s_d.phase == PH_TEST_GND) || (s_d.phase == PH_TEST_PVDD);
        // undervoltage is not latched, so the stage returns with the supply
        glob_fault = s_d.overtemp_error | uv_any;
        // a latched overload pulls the flag and takes out its own pair, or all four when paralleled
        sd_pull = test_next | (~rst_low & (glob_fault | (|s_d.overload_protect)));

        // half-bridges: global faults, reset and startup take all four off
        if ((s_d.phase != PH_RUN) || rst_low || glob_fault) begin
            s_d.hb.hiz = HB_ALL;
        end else begin
            s_d.hb.hiz = pair_off | p.boot_uv;
        end
        // weak pulldowns charge bootstraps; never while the test probes the pins
        s_d.hb.weak_pd = (rst_low && !s_d.cfg_se && !test_next) ? HB_ALL : HB_NONE;

        // open-drain flags; the level stays low, only the enable moves
        s_d.od.shutdown_flag_n_out = 1'b0;
        s_d.od.overtemp_warn_n_out = 1'b0;
        s_d.od.overtemp_warn_low_n_out = 1'b0;
        s_d.od.overtemp_warn_high_n_out = 1'b0;
        s_d.od.shutdown_flag_n_oe_n = ~sd_pull;
        s_d.od.overtemp_warn_n_oe_n = ~(p.temp_c > TEMP_WARN_HIGH_C);
        s_d.od.overtemp_warn_high_n_oe_n = ~(p.temp_c > TEMP_WARN_HIGH_C);
        // the low warning exists only in the three-level variant
        s_d.od.overtemp_warn_low_n_oe_n =
            ~(s_d.three_level && (p.temp_c > TEMP_WARN_LOW_C));
    end

    ////////////////////////////////////////////////////////////////////////////
    // power-on reset: stage off, flags released, overload cleared
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_q <= '0;
            s_q.phase <= PH_POR;
            s_q.overload_protect <= HB_NONE;
            s_q.hb.hiz <= HB_ALL;
            s_q.od.shutdown_flag_n_oe_n <= 1'b1;
            s_q.od.overtemp_warn_n_oe_n <= 1'b1;
            s_q.od.overtemp_warn_low_n_oe_n <= 1'b1;
            s_q.od.overtemp_warn_high_n_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign od = s_q.od;
    assign hb = s_q.hb;

    ////////////////////////////////////////////////////////////////////////////
    // checks on the driven outputs and on the phase and latch state
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_uv_shutdown;
        (s_q.phase == PH_RUN && p.reset_pin_n && p.uv_common)
            |=> (!od.shutdown_flag_n_oe_n && hb.hiz == HB_ALL);
    endproperty
    a_uv_shutdown: assert property (p_uv_shutdown)
        else $error("undervoltage did not shut the stage");

    property p_uv_recover;
        (s_q.phase == PH_RUN && p.reset_pin_n && !uv_any && s_q.overload_protect == HB_NONE && !s_q.overtemp_error
         && !(p.temp_c > TEMP_SHUT_C) && !(|p.overload) && $stable(p)) [*2]
            |-> (od.shutdown_flag_n_oe_n && hb.hiz == p.boot_uv);
    endproperty
    a_uv_recover: assert property (p_uv_recover)
        else $error("stage did not recover after fault cleared");

    property p_rst_release;
        (!p.reset_pin_n && s_q.phase == PH_RUN)
            |=> (od.shutdown_flag_n_oe_n && hb.hiz == HB_ALL);
    endproperty
    a_rst_release: assert property (p_rst_release)
        else $error("reset low did not release flag and stage");

    property p_warn_high;
        (p.temp_c > TEMP_WARN_HIGH_C)
            |=> (!od.overtemp_warn_high_n_oe_n && !od.overtemp_warn_n_oe_n);
    endproperty
    a_warn_high: assert property (p_warn_high)
        else $error("high warning missing above 125C");

    property p_warn_low;
        (s_q.phase == PH_RUN && s_q.three_level && p.temp_c > TEMP_WARN_LOW_C)
            |=> !od.overtemp_warn_low_n_oe_n;
    endproperty
    a_warn_low: assert property (p_warn_low)
        else $error("low warning missing above 100C");

    property p_two_level;
        (s_q.phase == PH_RUN && !s_q.three_level) |=> od.overtemp_warn_low_n_oe_n;
    endproperty
    a_two_level: assert property (p_two_level)
        else $error("low warning driven in two-level variant");

    property p_ote_hold;
        (s_q.overtemp_error && p.reset_pin_n) |=> (s_q.overtemp_error && hb.hiz == HB_ALL && !od.shutdown_flag_n_oe_n);
    endproperty
    a_ote_hold: assert property (p_ote_hold)
        else $error("overtemperature latch lost without reset");

    property p_test_flag;
        (s_q.phase == PH_TEST_GND || s_q.phase == PH_TEST_PVDD)
            |-> (!od.shutdown_flag_n_oe_n && hb.hiz == HB_ALL);
    endproperty
    a_test_flag: assert property (p_test_flag)
        else $error("flag released during short test");

    property p_step_order;
        (s_q.phase == PH_TEST_PVDD) |=> (s_q.phase != PH_TEST_GND);
    endproperty
    a_step_order: assert property (p_step_order)
        else $error("ground step after supply step");

    property p_run_stays;
        (s_q.phase == PH_RUN) |=> (s_q.phase == PH_RUN);
    endproperty
    a_run_stays: assert property (p_run_stays)
        else $error("left run phase after startup");

    property p_se_skip;
        (s_q.phase == PH_POR && s_q.settle == SYNC_SETTLE_CYC && !uv_any
         && p.single_ended_config) |=> (s_q.phase == PH_RUN);
    endproperty
    a_se_skip: assert property (p_se_skip)
        else $error("short test not skipped in single-ended mode");

    property p_boot_uv;
        (s_q.phase == PH_RUN && p.reset_pin_n && p.boot_uv[0] && !sd_pull)
            |=> (hb.hiz[0] && od.shutdown_flag_n_oe_n);
    endproperty
    a_boot_uv: assert property (p_boot_uv)
        else $error("bootstrap undervoltage handled wrongly");

    property p_olp_keep;
        (|s_q.overload_protect && !rst_rise) |=> (|s_q.overload_protect);
    endproperty
    a_olp_keep: assert property (p_olp_keep)
        else $error("overload cleared without reset edge");

    property p_weak_pd;
        (!p.reset_pin_n && s_q.phase == PH_RUN) |=> (hb.weak_pd == (s_q.cfg_se ? HB_NONE : HB_ALL));
    endproperty
    a_weak_pd: assert property (p_weak_pd)
        else $error("weak pulldown state wrong under reset");

    property p_por_wait;
        (s_q.phase == PH_POR && s_q.settle != SYNC_SETTLE_CYC) |=> (s_q.phase == PH_POR);
    endproperty
    a_por_wait: assert property (p_por_wait)
        else $error("startup left before pin levels settled");

    property p_olp_pair;
        (s_q.phase == PH_RUN && p.reset_pin_n && !glob_fault && !s_q.cfg_parallel_bridge_config
         && olp_next == 4'h1 && p.boot_uv == HB_NONE)
            |=> (hb.hiz == 4'h3 && !od.shutdown_flag_n_oe_n);
    endproperty
    a_olp_pair: assert property (p_olp_pair)
        else $error("overload did not take out exactly its pair");

    property p_olp_all;
        (s_q.phase == PH_RUN && p.reset_pin_n && s_q.cfg_parallel_bridge_config && (|olp_next))
            |=> (hb.hiz == HB_ALL && !od.shutdown_flag_n_oe_n);
    endproperty
    a_olp_all: assert property (p_olp_all)
        else $error("paralleled stage kept switching under overload");

    property p_flag_fault;
        (s_q.phase == PH_RUN && p.reset_pin_n && ((|olp_next) || s_d.overtemp_error))
            |=> !od.shutdown_flag_n_oe_n;
    endproperty
    a_flag_fault: assert property (p_flag_fault)
        else $error("shutdown flag not pulled on a latched fault");

    property p_test_no_pd;
        (s_q.phase == PH_TEST_GND || s_q.phase == PH_TEST_PVDD) |-> (hb.weak_pd == HB_NONE);
    endproperty
    a_test_no_pd: assert property (p_test_no_pd)
        else $error("weak pulldown on while the short test probes the pins");

    c_test_pass: cover property (s_q.phase == PH_TEST_PVDD ##1 s_q.phase == PH_RUN);
    c_short_held: cover property (s_q.short_seen && s_q.phase == PH_RUN);
    c_ote_clear: cover property (s_q.overtemp_error ##1 !s_q.overtemp_error);
    c_olp_clear: cover property (|s_q.overload_protect ##1 s_q.overload_protect == HB_NONE);
    c_pair_off: cover property (s_q.phase == PH_RUN && hb.hiz == 4'h3);

endmodule
`default_nettype wire

// ==== dv/afp_host_model.sv ====
// Purpose: behavioural controller on the far side of the shutdown flag and reset pin
// Assumes: sd_n is the pulled-up wire level of the shutdown flag
// Notes: HOLD_CYC stands in for the long wait after the flag falls, to keep runs short
`timescale 1ns/1ps
`default_nettype none
module afp_host_model #(
    parameter int unsigned HOLD_CYC = 30
) (
    input wire logic clk,
    input wire logic sd_n,
    input wire logic reset_req,
    output var logic reset_pin_n
);
    logic sd_n_q;
    int unsigned since_fall_q;

    ////////////////////////////////////////////////////////////////////////////
    // start released, as if the flag fell long ago
    initial begin
        reset_pin_n = 1'b1;
        sd_n_q = 1'b1;
        since_fall_q = HOLD_CYC;
    end

    // a request lowers reset at once; release waits out the hold after a flag fall,
    // so a slow release is what the bench sees after a recent fault
    always @(posedge clk) begin
        sd_n_q <= sd_n;
        if (sd_n_q && !sd_n) begin
            since_fall_q <= 0;
        end else if (since_fall_q < HOLD_CYC) begin
            since_fall_q <= since_fall_q + 1;
        end
        if (reset_req) begin
            reset_pin_n <= 1'b0;
        end else if (!reset_pin_n && since_fall_q >= HOLD_CYC && !(sd_n_q && !sd_n)) begin
            reset_pin_n <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== dv/afp_tb.sv ====
// Purpose: self-checking bench for the amplifier fault supervisor
// Assumes: short test step shortened to 20 cycles, 1 uF filter
// Notes: the shutdown flag level is rebuilt from its enable as a pulled-up wire
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (a), (e)); end end
module testbench;
    import afp_pkg::*;

    logic clk;
    logic resetn;
    logic reset_req;
    logic host_rst_n;
    logic sd_n;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [7:0] temps [4] = '{8'h64, 8'h65, 8'h7D, 8'h7E};
    afp_pins_t p;
    afp_pins_t pins;
    afp_od_t od;
    afp_hb_t hb;

    ////////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // host reset is folded into the pin bundle; the flag is seen as a pulled-up wire
    always_comb begin
        pins = p;
        pins.reset_pin_n = host_rst_n;
    end
    assign sd_n = od.shutdown_flag_n_oe_n ? 1'b1 : od.shutdown_flag_n_out;

    afp_ctrl #(.PIN_SHORT_CHECK_UNIT_CYC(20)) afp_ctrl_inst (.clk(clk), .resetn(resetn), .pins(pins),
        .od(od), .hb(hb));
    afp_host_model #(.HOLD_CYC(30)) afp_host_model_inst (.clk(clk), .sd_n(sd_n),
        .reset_req(reset_req), .reset_pin_n(host_rst_n));

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic chk_out(input logic sd_exp, input logic [3:0] hiz_exp);
        `CHK(sd_n, sd_exp)
        `CHK(hb.hiz, hiz_exp)
    endtask

    // straps are set while the supply is still low, so power-on phase samples them
    task automatic startup(input logic pb, input logic se, input logic tl, input logic [3:0] sg);
        resetn = 1'b0;
        p.uv_common = 1'b1;
        p.parallel_bridge_config = pb;
        p.single_ended_config = se;
        p.three_level = tl;
        p.short_gnd = sg;
        wait_cyc(6);
        resetn = 1'b1;
        wait_cyc(8);
        p.uv_common = 1'b0;
    endtask

    // host pulses reset; the release may be slowed by the hold after a flag fall
    task automatic host_reset(input logic [3:0] wpd);
        int n;
        reset_req = 1'b1;
        wait_cyc(8);
        chk_out(1'b1, 4'hF);
        `CHK(hb.weak_pd, wpd)
        reset_req = 1'b0;
        n = 0;
        while (host_rst_n !== 1'b1 && n < 100) begin
            wait_cyc(1);
            n++;
        end
        `CHK(host_rst_n, 1'b1)
        wait_cyc(8);
        chk_out(1'b1, 4'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic scn_startup();
        startup(1'b0, 1'b0, 1'b1, 4'h0);
        wait_cyc(8);
        reset_req = 1'b1;
        wait_cyc(10);
        chk_out(1'b0, 4'hF);
        reset_req = 1'b0;
        wait_cyc(8);
        chk_out(1'b0, 4'hF);
        wait_cyc(60);
        chk_out(1'b1, 4'h0);
        `CHK(od.shutdown_flag_n_out, 1'b0)
    endtask

    task automatic scn_warn(input logic tl);
        for (int i = 0; i < 4; i++) begin
            p.temp_c = temps[i];
            wait_cyc(8);
            `CHK(od.overtemp_warn_low_n_oe_n, !(tl && temps[i] > TEMP_WARN_LOW_C))
            `CHK(od.overtemp_warn_high_n_oe_n, !(temps[i] > TEMP_WARN_HIGH_C))
            `CHK(od.overtemp_warn_n_oe_n, !(temps[i] > TEMP_WARN_HIGH_C))
            `CHK(sd_n, 1'b1)
            `CHK({od.overtemp_warn_n_out, od.overtemp_warn_low_n_out, od.overtemp_warn_high_n_out}, 3'h0)
        end
        p.temp_c = 8'h32;
    endtask

    task automatic scn_self_clear();
        p.uv_gate = 4'h8;
        wait_cyc(8);
        chk_out(1'b0, 4'hF);
        p.uv_gate = 4'h0;
        wait_cyc(8);
        chk_out(1'b1, 4'h0);
        p.boot_uv = 4'h4;
        wait_cyc(8);
        chk_out(1'b1, 4'h4);
        p.boot_uv = 4'h0;
        p.short_pvdd = 4'h1;
        wait_cyc(8);
        chk_out(1'b1, 4'h0);
        p.short_pvdd = 4'h0;
    endtask

    task automatic scn_latch();
        p.overload = 4'h1;
        wait_cyc(8);
        chk_out(1'b0, 4'h3);
        p.overload = 4'h0;
        wait_cyc(10);
        chk_out(1'b0, 4'h3);
        host_reset(4'hF);
        p.temp_c = 8'h9C;
        wait_cyc(8);
        chk_out(1'b0, 4'hF);
        p.temp_c = 8'h32;
        wait_cyc(10);
        chk_out(1'b0, 4'hF);
        host_reset(4'hF);
    endtask

    // parallel config runs the test and waits out a short; single-ended skips it
    task automatic scn_configs();
        startup(1'b1, 1'b0, 1'b1, 4'h2);
        wait_cyc(100);
        chk_out(1'b0, 4'hF);
        p.short_gnd = 4'h0;
        wait_cyc(70);
        chk_out(1'b1, 4'h0);
        // paralleled: one overloaded half-bridge takes out all four
        p.overload = 4'h1;
        wait_cyc(8);
        chk_out(1'b0, 4'hF);
        p.overload = 4'h0;
        host_reset(4'hF);
        startup(1'b0, 1'b1, 1'b0, 4'h2);
        wait_cyc(12);
        chk_out(1'b1, 4'h0);
        scn_warn(1'b0);
        host_reset(4'h0);
        p.short_gnd = 4'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // verdict and hang guard
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end

    // main sequence
    initial begin
        p = '0;
        p.filt_cap_uf = 4'h1;
        p.temp_c = 8'h32;
        p.uv_common = 1'b1;
        p.reset_pin_n = 1'b1;
        resetn = 1'b0;
        reset_req = 1'b0;
        wait_cyc(3);
        resetn = 1'b1;
        wait_cyc(1);
        scn_startup();
        scn_warn(1'b1);
        scn_self_clear();
        scn_latch();
        scn_configs();
        test_done();
    end
endmodule
`undef CHK
`default_nettype wire
